/* cdci_top.sv */
// character display command interpreter, 20 digits, one row
// assumes 25 MHz ref_clk_i; pins are asynchronous to it
// Operation
// - busy high while a byte is processed
// - printable character advances position right
// - control byte values decoded as listed
// - byte after brightness code sets level
// - back space left, ignored at leftmost
// - tab right, ignored at rightmost
// - line feed blanks, keeps position
// - carriage return blanks, goes leftmost
// - byte after position code sets position
// - end-of-row mode governs rightmost writes
// - wrap mode code blanks, goes leftmost
// - wrap: next char restarts row blank
// - overwrite: position stays on rightmost
// - scroll: shift left, place rightmost
// - reset code equals power-on state
// - power-up blanks memory, selects wrap
// - self-check low cycles A to Z, 0 to 9, space to slash
// - self-check rejects parallel and serial writes; bus writes still land
// - jumpers select 1200 to 9600 baud
// - bit time 10^6/baud us, mid sampling
// - parallel latched on strobe rise, enable low
`timescale 1ns/100ps
`default_nettype none
module cdci_top #(
    parameter int BIT_CYC_1200 = cdci_pkg::BIT_CYC_SLOW,
    parameter int ST_STEP_CYC = cdci_pkg::ST_STEP_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] par_data_i,
    input wire logic par_strobe_i,
    input wire logic par_enable_low_i,
    input wire logic serial_rx_i,
    input wire logic self_check_low_i,
    input wire logic rate_jumper_a_i,
    input wire logic rate_jumper_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy_o,
    output logic [7:0] brightness_o,
    output logic [4:0] write_pos_o,
    output logic [8*cdci_pkg::NDIG-1:0] disp_chars_o
);
    import cdci_pkg::*;
    localparam int CNT_W = $clog2(BIT_CYC_1200 + 1);
    localparam int STW = $clog2(ST_STEP_CYC + 1);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (BIT_CYC_1200 < 64)
    begin : g_chk_baud
        $error("bit period too short for the fastest rate");
    end
    if (ST_STEP_CYC < 1)
    begin : g_chk_step
        $error("self-check step must be at least one cycle");
    end

    // ------------------------------------------------------------
    // pin synchronisers and receivers
    // ------------------------------------------------------------
    logic [1:0] chk_r, ja_r, jb_r;
    logic st_r;
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            chk_r <= 2'h3;
            ja_r <= 2'h3;
            jb_r <= 2'h3;
        end
        else
        begin
            chk_r <= {chk_r[0], self_check_low_i};
            ja_r <= {ja_r[0], rate_jumper_a_i};
            jb_r <= {jb_r[0], rate_jumper_b_i};
        end
    end
    // open jumper reads high through the pull-up
    wire [1:0] rate_sel = {jb_r[1], ja_r[1]};
    wire [CNT_W-1:0] bit_cyc = CNT_W'(BIT_CYC_1200) >> rate_sel;

    cdci_byte_if par_if ();
    cdci_byte_if ser_if ();
    cdci_par_rx u_par (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .par_data_i(par_data_i),
        .par_strobe_i(par_strobe_i),
        .par_enable_low_i(par_enable_low_i),
        .out_if(par_if.src)
    );
    cdci_uart_rx #(.CNT_W(CNT_W)) u_ser (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .rxd_i(serial_rx_i),
        .bit_cyc_i(bit_cyc),
        .out_if(ser_if.src)
    );

    // ------------------------------------------------------------
    // acceptance
    // ------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic busy_r;
    cdci_fsm_t fsm_r;
    logic [7:0] byte_r;
    // a byte arriving while busy is dropped, the host broke the handshake
    wire can_take = ~busy_r & ~st_r;
    assign par_if.rdy = can_take & ctrl_r[0];
    assign ser_if.rdy = can_take & ctrl_r[1];
    wire take_par = par_if.vld & par_if.rdy;
    wire take_ser = ser_if.vld & ser_if.rdy;
    wire take = take_par | take_ser;
    wire [7:0] take_dat = take_par ? par_if.dat : ser_if.dat;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [7:0] mem_r [NDIG];
    logic [7:0] cell_nxt [NDIG];
    logic [4:0] pos_r, pos_nxt;
    cdci_mode_t mode_r, mode_nxt;
    cdci_arg_t arg_r, arg_nxt;
    logic [7:0] bright_r, bright_nxt;
    logic edge_r, edge_nxt;
    logic wr_en, do_clr, do_shift;
    logic [4:0] wr_idx;
    wire exec = (fsm_r == FSM_EXEC);
    wire is_chr = (byte_r >= PRINT_MIN);
    wire at_last = (pos_r == POS_LAST);
    wire lvl_ok = (byte_r == LVL_100) | (byte_r == LVL_60)
        | (byte_r == LVL_40) | (byte_r == LVL_20);

    always_comb
    begin
        pos_nxt = pos_r;
        mode_nxt = mode_r;
        arg_nxt = ARG_NONE;
        bright_nxt = bright_r;
        edge_nxt = edge_r;
        wr_en = 1'b0;
        wr_idx = pos_r;
        do_clr = 1'b0;
        do_shift = 1'b0;
        if (!exec)
            arg_nxt = arg_r;
        else if (arg_r == ARG_BRIGHT)
        begin
            if (lvl_ok)
                bright_nxt = byte_r;
        end
        else if (arg_r == ARG_POS)
        begin
            if (byte_r <= {3'h0, POS_LAST})
            begin
                pos_nxt = byte_r[4:0];
                edge_nxt = 1'b0;
            end
        end
        else if (is_chr)
        begin
            wr_en = 1'b1;
            if (at_last && edge_r && mode_r == MODE_WRAP)
            begin
                do_clr = 1'b1;
                wr_idx = POS_HOME;
                pos_nxt = POS_HOME + 5'h01;
                edge_nxt = 1'b0;
            end
            else if (at_last && edge_r && mode_r == MODE_SCROLL)
            begin
                wr_en = 1'b0;
                do_shift = 1'b1;
            end
            else if (at_last)
                edge_nxt = 1'b1;
            else
                pos_nxt = pos_r + 5'h01;
        end
        else
        begin
            case (byte_r)
                CODE_BRIGHT:
                    arg_nxt = ARG_BRIGHT;
                CODE_BS:
                    if (pos_r != POS_HOME)
                    begin
                        pos_nxt = pos_r - 5'h01;
                        edge_nxt = 1'b0;
                    end
                CODE_HT:
                    if (!at_last)
                        pos_nxt = pos_r + 5'h01;
                CODE_LF:
                begin
                    do_clr = 1'b1;
                    edge_nxt = 1'b0;
                end
                CODE_CR:
                begin
                    do_clr = 1'b1;
                    pos_nxt = POS_HOME;
                    edge_nxt = 1'b0;
                end
                CODE_POS:
                    arg_nxt = ARG_POS;
                CODE_WRAP:
                begin
                    mode_nxt = MODE_WRAP;
                    do_clr = 1'b1;
                    pos_nxt = POS_HOME;
                    edge_nxt = 1'b0;
                end
                CODE_OVR:
                    mode_nxt = MODE_OVR;
                CODE_SCROLL:
                    mode_nxt = MODE_SCROLL;
                CODE_RESET:
                begin
                    mode_nxt = MODE_WRAP;
                    do_clr = 1'b1;
                    pos_nxt = POS_HOME;
                    edge_nxt = 1'b0;
                    bright_nxt = LVL_100;
                end
                default:
                    arg_nxt = ARG_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // character memory and self-check pattern
    // ------------------------------------------------------------
    logic [5:0] st_base_r;
    logic [STW-1:0] st_cnt_r;
    logic [7:0] st_chr [NDIG];

    function automatic logic [7:0] st_seq(input logic [5:0] k);
        if (k < 6'h1A)
            return 8'h41 + {2'h0, k};
        else if (k < 6'h24)
            return 8'h30 + {2'h0, k - 6'h1A};
        else
            return 8'h20 + {2'h0, k - 6'h24};
    endfunction

    for (genvar i = 0; i < NDIG; i++)
    begin : g_cell
        wire [6:0] k_raw = {1'b0, st_base_r} + 7'(i);
        wire [6:0] k = (k_raw >= 7'(ST_SEQ_LEN)) ? k_raw - 7'(ST_SEQ_LEN) : k_raw;
        wire [7:0] shl = (i == NDIG - 1) ? byte_r : mem_r[(i + 1) % NDIG];
        assign st_chr[i] = st_seq(k[5:0]);
        assign cell_nxt[i] = (wr_en && wr_idx == 5'(i)) ? byte_r
            : do_shift ? shl
            : do_clr ? BLANK
            : mem_r[i];
        always_ff @(posedge ref_clk_i or negedge rstn_i)
        begin
            if (!rstn_i)
            begin
                mem_r[i] <= BLANK;
                disp_chars_o[8*i +: 8] <= BLANK;
            end
            else
            begin
                mem_r[i] <= cell_nxt[i];
                disp_chars_o[8*i +: 8] <= st_r ? st_chr[i] : mem_r[i];
            end
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    wire st_step = st_r && (st_cnt_r == '0);
    wire [6:0] base_add = {1'b0, st_base_r} + 7'(NDIG);
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_r <= 1'b0;
            busy_r <= 1'b0;
            fsm_r <= FSM_IDLE;
            byte_r <= 8'h00;
            pos_r <= POS_HOME;
            mode_r <= MODE_WRAP;
            arg_r <= ARG_NONE;
            bright_r <= LVL_100;
            edge_r <= 1'b0;
            st_base_r <= 6'h00;
            st_cnt_r <= '0;
        end
        else
        begin
            st_r <= ~chk_r[1];
            busy_r <= take | ~chk_r[1];
            fsm_r <= take ? FSM_EXEC : FSM_IDLE;
            if (take)
                byte_r <= take_dat;
            pos_r <= pos_nxt;
            mode_r <= mode_nxt;
            arg_r <= arg_nxt;
            bright_r <= bright_nxt;
            edge_r <= edge_nxt;
            st_cnt_r <= (!st_r || st_step) ? STW'(ST_STEP_CYC - 1) : st_cnt_r - 1'b1;
            if (!st_r)
                st_base_r <= 6'h00;
            else if (st_step)
                st_base_r <= (base_add >= 7'(ST_SEQ_LEN))
                    ? 6'(base_add - 7'(ST_SEQ_LEN)) : base_add[5:0];
        end
    end
    assign busy_o = busy_r;
    assign brightness_o = bright_r;
    assign write_pos_o = pos_r;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [31:0] status_w = {14'h0000, st_r, busy_r, bright_r, 1'b0, mode_r, pos_r};
    wire [31:0] rd_w = (wb_adr_i == ADR_STATUS) ? status_w
        : (wb_adr_i == ADR_CTRL) ? {30'h0000_0000, ctrl_r}
        : 32'h0000_0000;
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r <= CTRL_RST;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i)
                wb_dat_o <= rd_w;
            if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
                ctrl_r <= wb_dat_i[1:0];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    wire ex_ctl = exec && arg_r == ARG_NONE && !is_chr;

    busy_take_a: assert property (take |=> busy_o ##1 (!busy_o || st_r))
        else $error("busy not a one-cycle pulse per byte");
    chk_block_a: assert property (st_r |-> !par_if.rdy && !ser_if.rdy)
        else $error("write accepted during self-check");
    chr_adv_a: assert property (exec && arg_r == ARG_NONE && is_chr && !at_last
        |=> pos_r == $past(pos_r) + 5'h01 && mem_r[$past(pos_r)] == $past(byte_r))
        else $error("character not stored or position not advanced");
    bs_left_a: assert property (ex_ctl && byte_r == CODE_BS
        |=> pos_r == (($past(pos_r) == POS_HOME) ? POS_HOME : $past(pos_r) - 5'h01))
        else $error("back space wrong");
    ht_right_a: assert property (ex_ctl && byte_r == CODE_HT && at_last
        |=> pos_r == POS_LAST)
        else $error("tab moved past rightmost digit");
    lf_keep_a: assert property (ex_ctl && byte_r == CODE_LF
        |=> $stable(pos_r) && mem_r[0] == BLANK && mem_r[NDIG-1] == BLANK)
        else $error("line feed wrong");
    cr_home_a: assert property (ex_ctl && byte_r == CODE_CR
        |=> pos_r == POS_HOME && mem_r[NDIG-1] == BLANK)
        else $error("carriage return wrong");
    pos_set_a: assert property (exec && arg_r == ARG_POS && byte_r <= 8'h13
        |=> pos_r == $past(byte_r[4:0]))
        else $error("position byte not applied");
    rst_code_a: assert property (ex_ctl && byte_r == CODE_RESET
        |=> mode_r == MODE_WRAP && pos_r == POS_HOME && bright_r == LVL_100)
        else $error("reset code state wrong");
    wrap_edge_a: assert property (exec && arg_r == ARG_NONE && is_chr && at_last
        && edge_r && mode_r == MODE_WRAP |=> pos_r == 5'h01 && mem_r[1] == BLANK)
        else $error("wrap restart wrong");
    scroll_fix_a: assert property (exec && arg_r == ARG_NONE && is_chr && at_last
        && mode_r == MODE_SCROLL |=> pos_r == POS_LAST && mem_r[NDIG-1] == $past(byte_r))
        else $error("scroll placement wrong");
    cov_par_c: cover property (take_par ##1 busy_o ##1 !busy_o);
    cov_ser_c: cover property (take_ser && ser_if.dat >= PRINT_MIN);
    cov_scroll_c: cover property (do_shift);
    cov_chk_c: cover property (st_step);
endmodule // cdci_top
`default_nettype wire

/* cdci_pkg.sv */
// constants, codes and types of the character display command interpreter
// assumes a 25 MHz reference clock
package cdci_pkg;
    // ------------------------------------------------------------
    // clock and serial timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int BIT_US_NUM = 1_000_000; // bit time in us is this over the baud rate
    localparam int BAUD_SLOW = 1200;
    localparam int BIT_CYC_SLOW = (CLK_HZ / BIT_US_NUM) * BIT_US_NUM / BAUD_SLOW;
    localparam int ST_STEP_MS = 500;
    localparam int ST_STEP_CYC = ST_STEP_MS * (CLK_HZ / 1000);
    // ------------------------------------------------------------
    // display geometry
    // ------------------------------------------------------------
    localparam int NDIG = 20;
    localparam int ST_SEQ_LEN = 52;
    localparam logic [4:0] POS_HOME = 5'h00;
    localparam logic [4:0] POS_LAST = 5'h13;
    localparam logic [7:0] BLANK = 8'h20;
    localparam logic [7:0] PRINT_MIN = 8'h20;
    // ------------------------------------------------------------
    // control codes and levels
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_BRIGHT = 8'h04;
    localparam logic [7:0] CODE_BS = 8'h08;
    localparam logic [7:0] CODE_HT = 8'h09;
    localparam logic [7:0] CODE_LF = 8'h0A;
    localparam logic [7:0] CODE_CR = 8'h0D;
    localparam logic [7:0] CODE_POS = 8'h10;
    localparam logic [7:0] CODE_WRAP = 8'h11;
    localparam logic [7:0] CODE_OVR = 8'h12;
    localparam logic [7:0] CODE_SCROLL = 8'h13;
    localparam logic [7:0] CODE_RESET = 8'h1F;
    localparam logic [7:0] LVL_100 = 8'hFF;
    localparam logic [7:0] LVL_60 = 8'h60;
    localparam logic [7:0] LVL_40 = 8'h40;
    localparam logic [7:0] LVL_20 = 8'h20;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_CTRL = 4'h4;
    localparam logic [1:0] CTRL_RST = 2'h3;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_WRAP, MODE_OVR, MODE_SCROLL} cdci_mode_t;
    typedef enum logic [1:0] {ARG_NONE, ARG_BRIGHT, ARG_POS} cdci_arg_t;
    typedef enum logic {FSM_IDLE, FSM_EXEC} cdci_fsm_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} cdci_rx_t;
endpackage

/* cdci_byte_if.sv */
// byte stream from a receiver to the interpreter core
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface cdci_byte_if;
    logic vld;
    logic rdy;
    logic [7:0] dat;
    modport src (output vld, output dat, input rdy);
    modport dst (input vld, input dat, output rdy);
endinterface
`default_nettype wire

/* cdci_uart_rx.sv */
// serial byte receiver: start, 8 data lsb first, stop, no parity
// assumes rxd idles high; a byte offered while rdy is low is dropped
`timescale 1ns/100ps
`default_nettype none
module cdci_uart_rx #(
    parameter int CNT_W = 15
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic rxd_i,
    input wire logic [CNT_W-1:0] bit_cyc_i,
    cdci_byte_if.src out_if
);
    import cdci_pkg::*;
    logic [1:0] sync_r;
    logic [CNT_W-1:0] cnt_r;
    logic [2:0] bitn_r;
    logic [7:0] sh_r;
    logic vld_r;
    cdci_rx_t st_r;
    wire rx = sync_r[1];
    wire tick = (cnt_r == '0);
    assign out_if.vld = vld_r;
    assign out_if.dat = sh_r;
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync_r <= 2'h3;
            cnt_r <= '0;
            bitn_r <= 3'h0;
            sh_r <= 8'h00;
            vld_r <= 1'b0;
            st_r <= RX_IDLE;
        end
        else
        begin
            sync_r <= {sync_r[0], rxd_i};
            vld_r <= 1'b0;
            cnt_r <= tick ? bit_cyc_i - 1'b1 : cnt_r - 1'b1;
            case (st_r)
                RX_IDLE:
                    if (!rx)
                    begin
                        st_r <= RX_START;
                        cnt_r <= bit_cyc_i >> 1; // mid-bit sampling
                    end
                RX_START:
                    if (tick)
                        st_r <= rx ? RX_IDLE : RX_DATA; // glitch filter
                RX_DATA:
                    if (tick)
                    begin
                        sh_r <= {rx, sh_r[7:1]};
                        bitn_r <= bitn_r + 3'h1;
                        if (bitn_r == 3'h7)
                            st_r <= RX_STOP;
                    end
                RX_STOP:
                    if (tick)
                    begin
                        vld_r <= rx; // valid at stop centre only if the stop bit is high; busy rises one cycle later
                        st_r <= RX_IDLE;
                    end
                default:
                    st_r <= RX_IDLE;
            endcase
        end
    end
endmodule // cdci_uart_rx
`default_nettype wire

/* cdci_par_rx.sv */
// parallel port: byte latched on strobe rise while enable is low
// assumes raw pins; all pass two flops before use
`timescale 1ns/100ps
`default_nettype none
module cdci_par_rx (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] par_data_i,
    input wire logic par_strobe_i,
    input wire logic par_enable_low_i,
    cdci_byte_if.src out_if
);
    import cdci_pkg::*;
    logic [7:0] d1_r, d2_r, dat_r;
    logic [2:0] stb_r;
    logic [1:0] en_r;
    logic vld_r;
    assign out_if.vld = vld_r;
    assign out_if.dat = dat_r;
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            d1_r <= 8'h00;
            d2_r <= 8'h00;
            dat_r <= 8'h00;
            stb_r <= 3'h7;
            en_r <= 2'h3;
            vld_r <= 1'b0;
        end
        else
        begin
            d1_r <= par_data_i;
            d2_r <= d1_r;
            stb_r <= {stb_r[1:0], par_strobe_i};
            en_r <= {en_r[0], par_enable_low_i};
            vld_r <= stb_r[1] & ~stb_r[2] & ~en_r[1];
            if (stb_r[1] & ~stb_r[2])
                dat_r <= d2_r;
        end
    end
endmodule // cdci_par_rx
`default_nettype wire

/* cdci_host_model.sv */
// host model: parallel strobe port and serial line
// assumes calls just after a rising edge; idle lines float high
`timescale 1ns/100ps
`default_nettype none
module cdci_host_model (
    input wire logic clk_i,
    output logic [7:0] data_o,
    output logic strobe_o,
    output logic en_low_o,
    output logic rxd_o
);
    initial {data_o, strobe_o, en_low_o, rxd_o} = 11'h7FF;
    task automatic par_wr(input logic [7:0] b);
        repeat (8) @(posedge clk_i);
        {data_o, en_low_o, strobe_o} <= {b, 2'h0};
        repeat (3) @(posedge clk_i);
        strobe_o <= 1'h1;
        repeat (3) @(posedge clk_i);
        {data_o, en_low_o} <= 9'h1FF;
    endtask
    // returns as the stop bit starts, so the caller can see busy
    task automatic ser_wr(input logic [7:0] b, input int n);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            repeat (n) @(posedge clk_i);
            rxd_o <= f[i];
        end
    endtask
endmodule // cdci_host_model
`default_nettype wire

/* test_char_display_command_interpreter.sv */
// bench: parallel, serial, bus and self-check traffic
// assumes short bit and page counts
`timescale 1ns/100ps
`default_nettype none
module test_char_display_command_interpreter;
    import cdci_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, tst_n = 1'h1, ja = 1'h1, jb = 1'h1, cyc = 1'h0, we = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rq;
    logic [7:0] lv [4] = '{LVL_100, LVL_60, LVL_40, LVL_20};
    int num_errors = 0, checks = 0;
    wire logic ack, busy, rxd, stp, enl;
    wire logic [7:0] bri, pd;
    wire logic [4:0] pos;
    wire logic [31:0] rd;
    wire logic [8*NDIG-1:0] dc;
    always #20 clk = ~clk;
    cdci_top #(.BIT_CYC_1200(64), .ST_STEP_CYC(4)) dut_u (.ref_clk_i(clk), .rstn_i(rstn),
        .par_data_i(pd), .par_strobe_i(stp), .par_enable_low_i(enl), .serial_rx_i(rxd),
        .self_check_low_i(tst_n), .rate_jumper_a_i(ja), .rate_jumper_b_i(jb), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .busy_o(busy), .brightness_o(bri), .write_pos_o(pos),
        .disp_chars_o(dc));
    cdci_host_model host (.clk_i(clk), .data_o(pd), .strobe_o(stp), .en_low_o(enl),
        .rxd_o(rxd));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        num_errors += (g !== e);
        if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        {cyc, we, adr, wd} <= {1'h1, w, a, d};
        do @(posedge clk); while (ack !== 1'h1);
        rq = rd;
        cyc <= 1'h0;
        @(posedge clk);
    endtask
    // n of zero means the parallel port, else cycles per serial bit
    task automatic wr(input logic [7:0] b, input int n = 0);
        while (busy !== 1'h0) @(posedge clk);
        if (n == 0) host.par_wr(b);
        else host.ser_wr(b, n);
        for (int k = 0; k < 40 && busy !== 1'h1; k++) @(posedge clk);
        chk("busy", 1'h1, busy);
        repeat (3) @(posedge clk);
    endtask
    task automatic wrs(input logic [7:0] q [$]);
        foreach (q[i]) wr(q[i]);
    endtask
    task automatic t_reset();
        chk("reset", {8'hFF, POS_HOME, BLANK}, {bri, pos, dc[7:0]});
        wb(ADR_STATUS, 1'h0, 32'h0);
        chk("mode", MODE_WRAP, rq[6:5]);
        wb(ADR_CTRL, 1'h1, 32'h2);
        wb(ADR_CTRL, 1'h0, 32'h0);
        chk("ctrl", 32'h2, rq);
        host.par_wr(8'h41);
        repeat (4) @(posedge clk);
        chk("gate", {1'h0, POS_HOME}, {busy, pos});
        wb(ADR_CTRL, 1'h1, 32'h3);
        wb(4'hC, 1'h0, 32'h0);
        chk("unmapped", 32'h0, rq);
        $display("test reset done");
    endtask
    task automatic t_edit();
        wrs('{8'h41, 8'h42, 8'h08, 8'h08, 8'h08, 8'h09});
        chk("pos", 5'h01, pos);
        wrs('{CODE_POS, 8'h13, 8'h09, 8'h43});
        chk("pos", POS_LAST, pos);
        wr(8'h44);
        chk("wrap", {5'h01, BLANK, 8'h44}, {pos, dc[159:152], dc[7:0]});
        wr(8'h0A);
        chk("lf", {5'h01, BLANK}, {pos, dc[7:0]});
        wr(8'h0D);
        chk("cr", POS_HOME, pos);
        wrs('{CODE_OVR, CODE_POS, 8'h13, 8'h45, 8'h46});
        chk("ovr", {POS_LAST, 8'h46}, {pos, dc[159:152]});
        wrs('{CODE_SCROLL, 8'h47});
        chk("scroll", 16'h4746, dc[159:144]);
        wr(CODE_WRAP);
        chk("home", {POS_HOME, BLANK}, {pos, dc[159:152]});
        foreach (lv[i])
        begin
            wrs('{CODE_BRIGHT, lv[i]});
            chk("bright", lv[i], bri);
        end
        wrs('{8'h48, CODE_RESET});
        chk("rst", {8'hFF, POS_HOME, BLANK}, {bri, pos, dc[7:0]});
        $display("test edit done");
    endtask
    task automatic t_ports();
        wr(8'h53, 8);
        {ja, jb} <= 2'h0;
        wr(8'h54, 64);
        chk("serial", 16'h5453, dc[15:0]);
        tst_n <= 1'h0;
        host.par_wr(8'h5A);
        chk("test", 1'h1, busy);
        for (int k = 0; k < 60 && dc[7:0] !== 8'h41; k++) @(posedge clk);
        chk("letters", 8'h54, dc[159:152]);
        for (int k = 0; k < 60 && dc[7:0] !== 8'h55; k++) @(posedge clk);
        chk("order", 16'h2130, {dc[143:136], dc[55:48]});
        wb(ADR_STATUS, 1'h0, 32'h0);
        chk("status", 2'h3, rq[17:16]);
        tst_n <= 1'h1;
        repeat (10) @(posedge clk);
        chk("reject", 5'h02, pos);
        chk("restore", 16'h5453, dc[15:0]);
        $display("test ports done");
    endtask
    task automatic end_of_test(input bit hung);
        num_errors += hung;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial #400_000 end_of_test(1'h1);
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        t_reset();
        t_edit();
        t_ports();
        end_of_test(1'h0);
    end
endmodule // test_char_display_command_interpreter
`default_nettype wire
